// file: design/adc_status_mode_registers.sv
// Status and mode registers behind the serial register port
`timescale 1ns/1ns
module adc_status_mode_registers
  import adc_regs_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire pins_type pins,
  input wire result_type result,
  input wire logic updateWarn,
  input wire logic lowPowerEntry,
  input wire logic refBelow,
  input wire logic referenceDetectEnable,
  input wire logic calActive,
  input wire logic calRefBad,
  input wire logic calRangeBad,
  output logic doutRdy,
  output logic doutEnable,
  output logic filterReset,
  output logic [23:0] operatingSetup,
  output logic [7:0] converterFlags
);

  //--------------------------------------------------------------------
  // State record
  //--------------------------------------------------------------------
  typedef struct packed {
    pins_type syncFirst;
    pins_type syncSecond;
    logic sclkLast;
    link_state_type link;
    logic [5:0] bitCnt;
    logic [5:0] txLen;
    logic [2:0] sel;
    logic isData;
    logic [31:0] shiftReg;
    logic [7:0] flags;
    logic [23:0] mode;
    logic [23:0] dataReg;
    logic filterReset;
    logic doutRdy;
    logic doutEnable;
  } state_type;

  state_type cur;
  state_type next_cur;

  // Sampled pin views, all from the second synchroniser stage
  logic selectedN;
  logic riseEdge;
  logic fallEdge;
  logic bitIn;
  logic [7:0] cmdByte;
  logic [31:0] rxWord;
  logic dataReadDone;
  logic modeWrite;

  assign selectedN = cur.syncSecond.selectN;
  assign riseEdge = cur.syncSecond.sclk & ~cur.sclkLast & ~selectedN;
  assign fallEdge = ~cur.syncSecond.sclk & cur.sclkLast & ~selectedN;
  assign bitIn = cur.syncSecond.din;
  assign cmdByte = {cur.shiftReg[6:0], bitIn};
  assign rxWord = {cur.shiftReg[30:0], bitIn};

  //--------------------------------------------------------------------
  // Next-state logic
  //--------------------------------------------------------------------
  // Serial link, flags and mode word in one pass; sets placed last win
  always_comb begin
    next_cur = cur;
    dataReadDone = 1'b0;
    modeWrite = 1'b0;
    next_cur.syncFirst = pins;
    next_cur.syncSecond = cur.syncFirst;
    next_cur.sclkLast = cur.syncSecond.sclk;
    next_cur.filterReset = 1'b0;

    // Deselect aborts any transfer and waits for a fresh command
    if (selectedN) begin
      next_cur.link = LINK_CMD;
      next_cur.bitCnt = 6'h00;
    end else begin
      case (cur.link)
        LINK_CMD: begin
          // A leading one is the write-enable guard; hold position
          if (riseEdge && !(cur.bitCnt == 6'h00 && bitIn)) begin
            next_cur.shiftReg = rxWord;
            next_cur.bitCnt = cur.bitCnt + 6'h01;
            if (cur.bitCnt == CMD_LEN - 6'h01) begin
              next_cur.bitCnt = 6'h00;
              next_cur.sel =
                cmdByte[REGISTER_SELECT_MSB:REGISTER_SELECT_LSB];
              next_cur.isData = 1'b0;
              if (cmdByte[CMD_READ_BIT]) begin
                next_cur.link = LINK_TX;
                if (next_cur.sel == SEL_STATUS) begin
                  // MSB first from the top of the shifter
                  next_cur.shiftReg = {cur.flags, 24'h000000};
                  next_cur.txLen = STATUS_LEN;
                end else if (next_cur.sel == SEL_MODE) begin
                  next_cur.shiftReg = {cur.mode, 8'h00};
                  next_cur.txLen = WORD_LEN;
                end else if (next_cur.sel == SEL_DATA) begin
                  next_cur.isData = 1'b1;
                  next_cur.shiftReg = {cur.dataReg, cur.flags};
                  // Status byte rides behind the data
                  next_cur.txLen = cur.mode[STATUS_APPEND_BIT] ?
                    WORD_STATUS_LEN : WORD_LEN;
                end else begin
                  // Registers kept elsewhere read as ones here
                  next_cur.shiftReg = 32'hFFFFFFFF;
                  next_cur.txLen = WORD_LEN;
                end
              end else if (next_cur.sel == SEL_MODE) begin
                next_cur.link = LINK_RX;
              end
            end
          end
        end
        LINK_RX: begin
          // Mode write arrives bit 23 first
          if (riseEdge) begin
            next_cur.shiftReg = rxWord;
            next_cur.bitCnt = cur.bitCnt + 6'h01;
            if (cur.bitCnt == WORD_LEN - 6'h01) begin
              next_cur.bitCnt = 6'h00;
              next_cur.link = LINK_CMD;
              modeWrite = 1'b1;
              next_cur.mode = rxWord[23:0];
              // Bit 14 is not writable
              next_cur.mode[FIXED_ZERO_BIT] = 1'b0;
            end
          end
        end
        LINK_TX: begin
          // Host samples on rising edges; next bit appears on falling
          if (riseEdge) begin
            next_cur.bitCnt = cur.bitCnt + 6'h01;
            if (cur.bitCnt == cur.txLen - 6'h01) begin
              next_cur.bitCnt = 6'h00;
              next_cur.link = LINK_CMD;
              dataReadDone = cur.isData;
            end
          end
          // First bit already stands since the command's last rise,
          // so the opening fall must not push it out unread
          if (fallEdge && cur.bitCnt != 6'h00) begin
            next_cur.shiftReg = {cur.shiftReg[30:0], 1'b1};
          end
        end
        default: begin
          next_cur.link = LINK_CMD;
        end
      endcase
    end

    // Missing reference tracks the comparator only when enabled
    next_cur.flags[MISSING_REF_BIT] =
      referenceDetectEnable & refBelow;

    // New result: store, tag, judge error, clear not-ready
    if (result.strobe) begin
      // Low reference forces a full-scale code
      next_cur.dataReg = cur.flags[MISSING_REF_BIT] ?
        24'hFFFFFF : result.word;
      next_cur.flags[NOT_READY_BIT] = 1'b0;
      next_cur.flags[ERROR_BIT] =
        result.clamped | cur.flags[MISSING_REF_BIT];
      next_cur.flags[TAG_MSB:0] = result.channel;
    end

    // Parity follows the stored word, zero when disabled
    next_cur.flags[PARITY_BIT] =
      cur.mode[PARITY_ENABLE_BIT] & (^next_cur.dataReg);

    // Calibration faults raise the error flag
    if (calActive && (calRefBad || calRangeBad)) begin
      next_cur.flags[ERROR_BIT] = 1'b1;
    end

    // Sets of not-ready sit after the clear so a collision stays set
    if (dataReadDone || updateWarn) begin
      next_cur.flags[NOT_READY_BIT] = 1'b1;
    end
    if (lowPowerEntry || !cur.syncSecond.syncN) begin
      next_cur.flags[NOT_READY_BIT] = 1'b1;
    end
    if (modeWrite) begin
      next_cur.flags[NOT_READY_BIT] = 1'b1;
      next_cur.filterReset = 1'b1;
    end

    // Pin shows shifter while reading, else ready state
    next_cur.doutEnable = ~selectedN;
    next_cur.doutRdy = (next_cur.link == LINK_TX) ?
      next_cur.shiftReg[31] : next_cur.flags[NOT_READY_BIT];
  end

  //--------------------------------------------------------------------
  // State register
  //--------------------------------------------------------------------
  // Pins idle high after reset so no false edge is seen
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cur <= '0;
      cur.syncFirst <= 4'hF;
      cur.syncSecond <= 4'hF;
      cur.sclkLast <= 1'b1;
      cur.link <= LINK_CMD;
      cur.flags <= FLAGS_RESET;
      cur.mode <= MODE_RESET;
      cur.doutRdy <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from the state flops
  assign doutRdy = cur.doutRdy;
  assign doutEnable = cur.doutEnable;
  assign filterReset = cur.filterReset;
  assign operatingSetup = cur.mode;
  assign converterFlags = cur.flags;

  //--------------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  sequence modeLastBit;
    cur.link == LINK_RX && riseEdge && cur.bitCnt == WORD_LEN - 6'h01;
  endsequence

  sequence statusCmdDone;
    cur.link == LINK_CMD && riseEdge && !selectedN &&
      cur.bitCnt == CMD_LEN - 6'h01 && cmdByte[CMD_READ_BIT] &&
      cmdByte[5:3] == SEL_STATUS;
  endsequence

  status_reset_a: assert property (
    $fell(srst) |-> $past(converterFlags) == FLAGS_RESET)
    else $error("status reset value wrong");
  mode_reset_a: assert property (
    $fell(srst) |-> $past(operatingSetup) == MODE_RESET)
    else $error("mode reset value wrong");
  status_msb_a: assert property (
    statusCmdDone |=> doutRdy == $past(cur.flags[7]))
    else $error("status msb not first");
  mode_write_a: assert property (
    modeLastBit |=> filterReset && converterFlags[NOT_READY_BIT] &&
      operatingSetup[FIXED_ZERO_BIT] == 1'b0)
    else $error("mode write side effects missing");
  ready_clear_a: assert property (
    result.strobe && !updateWarn && !lowPowerEntry &&
      cur.syncSecond.syncN && !modeWrite && !dataReadDone
      |=> !converterFlags[NOT_READY_BIT])
    else $error("ready not cleared on result");
  sync_low_a: assert property (
    !cur.syncSecond.syncN |=> converterFlags[NOT_READY_BIT])
    else $error("sync low did not set not-ready");
  error_follow_a: assert property (
    result.strobe && !calActive |=>
      converterFlags[ERROR_BIT] ==
      ($past(result.clamped) | $past(cur.flags[MISSING_REF_BIT])))
    else $error("error flag mismatch");
  missing_ref_a: assert property (
    !referenceDetectEnable |=> !converterFlags[MISSING_REF_BIT])
    else $error("reference flag while detect off");
  parity_bit_a: assert property (
    converterFlags[PARITY_BIT] ==
      ($past(operatingSetup[PARITY_ENABLE_BIT]) & (^cur.dataReg)))
    else $error("parity bit wrong");
  channel_tag_a: assert property (
    result.strobe |=> converterFlags[3:0] == $past(result.channel))
    else $error("channel tag wrong");
  data_read_a: assert property (
    dataReadDone |=> converterFlags[NOT_READY_BIT])
    else $error("data read left ready");

  // Idle pin mirrors not-ready so the host may watch it instead
  ready_pin_a: assert property (
    cur.link != LINK_TX |-> doutRdy == converterFlags[NOT_READY_BIT])
    else $error("ready pin differs from flag");
  dout_release_a: assert property (
    selectedN |=> !doutEnable)
    else $error("pin driven while deselected");

  // Low reference forces the stored word to full scale
  clamp_ones_a: assert property (
    result.strobe && cur.flags[MISSING_REF_BIT] |=>
      cur.dataReg == 24'hFFFFFF)
    else $error("result not clamped to ones");

  // Restart is a single pulse per write
  restart_pulse_a: assert property (
    filterReset |=> !filterReset)
    else $error("restart pulse too long");

  // Mode word moves only on the last bit of a mode write
  mode_steady_a: assert property (
    !(cur.link == LINK_RX && riseEdge &&
      cur.bitCnt == WORD_LEN - 6'h01) |=> $stable(operatingSetup))
    else $error("mode changed without a write");
endmodule

// file: common/adc_regs_pkg.sv
// Constants and types for the converter status and mode register bank
//----------------------------------------------------------------------
// Operation
//----------------------------------------------------------------------
// Operation
// - Status register is 8 bits, read only, resets to 0x80.
// - Status bits leave most significant first, bit 7 down to 0.
// - Not-ready flag clears when a new result enters the data register.
// - Not-ready sets after a data read and before the next overwrite.
// - Not-ready sets on power-down or idle entry and sync held low.
// - Data-out/ready pin also shows end of conversion.
// - Error flag updates with ready; set when result is clamped.
// - Error flag clears once a written result is back in range.
// - Calibration sets error on bad reference or out-of-range inputs.
// - Missing-reference flag follows low reference; results clamp to ones.
// - Missing-reference detection acts only while detect enable is 1.
// - With parity enabled, bit 4 is the odd parity of the data register.
// - Bits 3..0 tag the channel that produced the stored result.
// - Mode register is 24 bits read/write, code 001, resets 0x080060.
// - Mode transfers carry bit 23 first, bit 0 last, both directions.
// - Any mode write resets modulator and filter and sets not-ready.
// - Mode bits: select 23..21, append 20, clock 19..18, average 17..16.
// - Mode bits: third_order_filter_select 15, zero 14, parity 13, div 12, single 11, rej 10.
package adc_regs_pkg;
  // Register select codes
  localparam logic [2:0] SEL_STATUS = 3'h0;
  localparam logic [2:0] SEL_MODE = 3'h1;
  localparam logic [2:0] SEL_DATA = 3'h3;
  localparam logic [7:0] FLAGS_RESET = 8'h80;
  localparam logic [23:0] MODE_RESET = 24'h080060;
  // Status bit positions
  localparam int NOT_READY_BIT = 7;
  localparam int ERROR_BIT = 6;
  localparam int MISSING_REF_BIT = 5;
  localparam int PARITY_BIT = 4;
  localparam int TAG_MSB = 3;
  // Mode field positions
  localparam int OP_MODE_MSB = 23;
  localparam int OP_MODE_LSB = 21;
  localparam int STATUS_APPEND_BIT = 20;
  localparam int CLOCK_SOURCE_MSB = 19;
  localparam int CLOCK_SOURCE_LSB = 18;
  localparam int AVERAGING_HI_BIT = 17;
  localparam int AVERAGING_LO_BIT = 16;
  localparam int THIRD_ORDER_BIT = 15;
  localparam int FIXED_ZERO_BIT = 14;
  localparam int PARITY_ENABLE_BIT = 13;
  localparam int CLOCK_DIVIDE_BIT = 12;
  localparam int SINGLE_CYCLE_BIT = 11;
  localparam int SIXTY_HZ_BIT = 10;
  localparam int RATE_WORD_MSB = 9;
  // Command byte layout
  localparam int CMD_WRITE_ENABLE_BIT = 7;
  localparam int CMD_READ_BIT = 6;
  localparam int REGISTER_SELECT_MSB = 5;
  localparam int REGISTER_SELECT_LSB = 3;
  // Transfer lengths in bits
  localparam logic [5:0] CMD_LEN = 6'h08;
  localparam logic [5:0] STATUS_LEN = 6'h08;
  localparam logic [5:0] WORD_LEN = 6'h18;
  localparam logic [5:0] WORD_STATUS_LEN = 6'h20;

  typedef enum logic [1:0] {
    LINK_CMD = 2'b00,
    LINK_RX = 2'b01,
    LINK_TX = 2'b10
  } link_state_type;

  // Serial pins, sampled together
  typedef struct packed {
    logic selectN;
    logic sclk;
    logic din;
    logic syncN;
  } pins_type;

  // One conversion result from the modulator side
  typedef struct packed {
    logic strobe;
    logic [23:0] word;
    logic clamped;
    logic [3:0] channel;
  } result_type;
endpackage

// file: sim/serial_host_model.sv
// Host side model that drives the serial register port
`timescale 1ns/1ns
module serial_host_model
  import adc_regs_pkg::*;
(
  input wire logic core_clk,
  input wire logic doutRdy,
  input wire logic doutEnable,
  output pins_type pins
);
  //--------------------------------------------------------------
  // Line level and idle pins
  //--------------------------------------------------------------
  // Released line floats up, so an undriven pin reads as ones
  wire lineLevel = doutEnable ? doutRdy : 1'b1;

  // Idle high keeps stray clocks from forming a command
  initial pins = '1;

  //--------------------------------------------------------------
  // Framed transfer
  //--------------------------------------------------------------
  // Command then n bits, MSB first; slow halves suit the synchronisers
  task automatic frame(input logic [7:0] cmd, input logic [31:0] dat,
                       input int n, output logic [31:0] rx);
    int i;
    logic b;
    rx = '0;
    pins.selectN <= 1'b0;
    repeat (3) @(posedge core_clk);
    for (i = 0; i < 8 + n; i++) begin
      b = (i < 8) ? cmd[7 - i] : dat[n - 1 - (i - 8)];
      pins.sclk <= 1'b0;
      pins.din <= b;
      repeat (6) @(posedge core_clk);
      pins.sclk <= 1'b1;
      rx = {rx[30:0], lineLevel};
      repeat (6) @(posedge core_clk);
    end
    pins.selectN <= 1'b1;
    pins.din <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask
endmodule

// file: sim/adc_status_mode_registers_tb_top.sv
// Self-checking bench for the status and mode register bank
`timescale 1ns/1ns
module adc_status_mode_registers_tb_top import adc_regs_pkg::*;;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  pins_type pins;
  result_type result = '0;
  logic updateWarn = 1'b0;
  logic lowPowerEntry = 1'b0;
  logic refBelow = 1'b0;
  logic referenceDetectEnable = 1'b0;
  logic calActive = 1'b0;
  logic calRefBad = 1'b0;
  logic calRangeBad = 1'b0;
  logic doutRdy, doutEnable, filterReset;
  logic [23:0] operatingSetup;
  logic [7:0] converterFlags;
  logic [31:0] rx;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  int resets = 0;

  //--------------------------------------------------------------
  // Clock, instances, watchdog
  //--------------------------------------------------------------
  always #50 core_clk = ~core_clk;

  adc_status_mode_registers adc_status_mode_registers_inst (
    .core_clk(core_clk), .srst(srst), .pins(pins), .result(result),
    .updateWarn(updateWarn), .lowPowerEntry(lowPowerEntry),
    .refBelow(refBelow), .referenceDetectEnable(referenceDetectEnable),
    .calActive(calActive), .calRefBad(calRefBad),
    .calRangeBad(calRangeBad), .doutRdy(doutRdy),
    .doutEnable(doutEnable), .filterReset(filterReset),
    .operatingSetup(operatingSetup), .converterFlags(converterFlags));

  serial_host_model serial_host_model_inst (
    .core_clk(core_clk), .doutRdy(doutRdy), .doutEnable(doutEnable),
    .pins(pins));

  // Restart pulses counted mid-cycle, away from the launching edge
  always @(negedge core_clk) begin
    if (filterReset) resets++;
  end

  // Ceiling is about seven times the run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  //--------------------------------------------------------------
  // Tasks
  //--------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // One-cycle result strobe, then room for the flags to land
  task automatic conv(input logic [23:0] w, input logic c,
                      input logic [3:0] ch);
    result <= '{1'b1, w, c, ch};
    tick(1);
    result.strobe <= 1'b0;
    tick(2);
  endtask

  // Clear not-ready, then raise it by warning, low power or sync
  task automatic hold7(input int k);
    conv(24'h000001, 1'b0, 4'h1);
    chk(converterFlags, 8'h01);
    if (k == 0) updateWarn <= 1'b1;
    else if (k == 1) lowPowerEntry <= 1'b1;
    else serial_host_model_inst.pins.syncN <= 1'b0;
    tick(3);
    updateWarn <= 1'b0;
    lowPowerEntry <= 1'b0;
    serial_host_model_inst.pins.syncN <= 1'b1;
    tick(3);
    chk(converterFlags, 8'h81);
  endtask

  //--------------------------------------------------------------
  // Main sequence
  //--------------------------------------------------------------
  initial begin
    tick(5);
    srst <= 1'b0;
    tick(1);
    chk(converterFlags, 8'h80);
    chk(operatingSetup, 24'h080060);
    chk(doutRdy, 1'b1);
    chk(doutEnable, 1'b0);
    tick(3);
    serial_host_model_inst.frame(8'h40, 0, 8, rx);
    chk(rx[7:0], 8'h80);
    conv(24'h000001, 1'b0, 4'hA);
    chk(doutRdy, 1'b0);
    serial_host_model_inst.frame(8'h40, 0, 8, rx);
    chk(rx[7:0], 8'h0A);
    for (int k = 0; k < 3; k++) hold7(k);
    conv(24'hFFFFFF, 1'b1, 4'h5);
    chk(converterFlags, 8'h45);
    conv(24'h000000, 1'b0, 4'h5);
    chk(converterFlags, 8'h05);
    // Bad reference, then bad inputs, each during a calibration
    for (int k = 0; k < 2; k++) begin
      calActive <= 1'b1;
      calRefBad <= (k == 0);
      calRangeBad <= (k == 1);
      tick(3);
      chk(converterFlags[6], 1'b1);
      calActive <= 1'b0;
      calRefBad <= 1'b0;
      calRangeBad <= 1'b0;
      tick(1);
      conv(24'h000000, 1'b0, 4'h5);
      chk(converterFlags, 8'h05);
    end
    referenceDetectEnable <= 1'b1;
    refBelow <= 1'b1;
    tick(3);
    chk(converterFlags[5], 1'b1);
    conv(24'h000000, 1'b0, 4'h2);
    chk(converterFlags, 8'h62);
    referenceDetectEnable <= 1'b0;
    tick(3);
    chk(converterFlags[5], 1'b0);
    refBelow <= 1'b0;
    // Same word twice: every write restarts, bit 14 stays zero
    for (int k = 0; k < 2; k++) begin
      serial_host_model_inst.frame(8'h08, 32'hB2E5A3, 24, rx);
      chk(operatingSetup, 24'hB2A5A3);
      chk(converterFlags[7], 1'b1);
      chk(resets, k + 1);
    end
    serial_host_model_inst.frame(8'h48, 0, 24, rx);
    chk(rx[23:0], 24'hB2A5A3);
    // A register kept elsewhere reads back as ones
    serial_host_model_inst.frame(8'h50, 0, 24, rx);
    chk(rx[23:0], 24'hFFFFFF);
    conv(24'h000007, 1'b0, 4'h3);
    chk(converterFlags, 8'h13);
    serial_host_model_inst.frame(8'h58, 0, 32, rx);
    chk(rx, 32'h00000713);
    chk(converterFlags, 8'h93);
    conv(24'h000003, 1'b0, 4'h3);
    chk(converterFlags, 8'h03);
    serial_host_model_inst.frame(8'h00, 0, 8, rx);
    chk(converterFlags, 8'h03);
    report_and_stop();
  end
endmodule
